// File: adc_seq_pkg.sv
// constants and types for the incremental adc conversion sequencer
// Operation
// RL1 - start or alt trigger begins conversion
// RL2 - n elementary conversions then one quantization
// RL3 - elementary conversion lasts ratio plus one periods
// RL4 - result is mean of elementary results
// RL5 - offset polarity alternates per elementary conversion
// RL6 - few extra cycles set up and end
// RL7 - bandgap held high, low, toggled, half toggled
// RL8 - strobe from 4 mhz, four frequencies
// RL9 - ratio is two to three plus code
// RL10 - count is two to the code
// RL11 - resolution capped at sixteen bits
// RL12 - total periods count times ratio+1 plus one
// RL13 - continuous mode repeats back to back
// RL14 - software should program two or more conversions
// RL15 - host avoids unserviceable fast rates
// RL16 - sixteen bit two's complement, saturating; the code truncates the mean and its 7fff clamp never fires
// RL17 - unused low bits forced per settings
// RL18 - result register updated only at end
package adc_seq_pkg;
	localparam logic [11:0] ADDR_RESULT = 12'h000;
	localparam logic [11:0] ADDR_CFG0 = 12'h004;
	localparam logic [11:0] ADDR_CFG2 = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00c;
	localparam int CFG0_START_BIT = 7;
	localparam int CFG0_ALT_BIT = 0;
	localparam int CFG0_CONT_BIT = 1;
	localparam int CFG0_RATIO_LSB = 2;
	localparam int CFG0_COUNT_LSB = 5;
	localparam int CFG2_FREQ_LSB = 6;
	localparam int CFG2_BG_LSB = 0;
	localparam logic [7:0] CFG0_RESET = 8'h00;
	localparam logic [7:0] CFG2_RESET = 8'h00;
	localparam int OSC_HZ = 4000000;
	localparam int SYS_HZ = 100000000;
	localparam int OSC_DIV = SYS_HZ / OSC_HZ;
	localparam int FS_DIV_MAX = 64;
	localparam int SETUP_CYCLES = 2;
	localparam int END_CYCLES = 2;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_ELEM = 3'b011,
		ST_QUANT = 3'b010,
		ST_END = 3'b110
	} seq_state_e;
	typedef enum logic [1:0]
	{
		BG_HIGH = 2'b00,
		BG_LOW = 2'b01,
		BG_TOGGLE = 2'b10,
		BG_HALF = 2'b11
	} bandgap_mode_e;
endpackage

// File: strobe_if.sv
// strobe carrier between sequencer and timebase
`timescale 1ns/1ps
`default_nettype none
interface strobe_if;
	logic [1:0] freq_sel;
	logic run;
	logic fs_tick;
	modport gen (input freq_sel, input run, output fs_tick);
	modport use_side (output freq_sel, output run, input fs_tick);
endinterface
`default_nettype wire

// File: oversample_timebase.sv
// over-sampling strobe generator from the 4 mhz oscillator rate
`timescale 1ns/1ps
`default_nettype none
module oversample_timebase
	import adc_seq_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	strobe_if.gen sif
);
	logic [4:0] osc_cnt;
	logic [5:0] fs_cnt;
	logic osc_tick;
	logic [5:0] fs_last;
	assign osc_tick = (osc_cnt == 5'(OSC_DIV - 1));
	// 4 mhz / 64,32,16,8 gives 62.5..500 khz
	assign fs_last = 6'((FS_DIV_MAX >> sif.freq_sel) - 1); // RL8
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			osc_cnt <= 5'h00;
			fs_cnt <= 6'h00;
			sif.fs_tick <= 1'b0;
		end
		else
		begin
			osc_cnt <= osc_tick ? 5'h00 : osc_cnt + 5'h01;
			sif.fs_tick <= sif.run && osc_tick && (fs_cnt >= fs_last); // RL8
			if (!sif.run)
				fs_cnt <= 6'h00;
			else if (osc_tick)
				fs_cnt <= (fs_cnt >= fs_last) ? 6'h00 : fs_cnt + 6'h01;
		end
	end
	// a strobe outside the run window would clock a stale elementary result
	property p_div_ok;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		sif.fs_tick |-> sif.run;
	endproperty
	a_div_ok: assert property (p_div_ok) else $error("strobe outside run"); // RL8
endmodule
`default_nettype wire

// File: adc_conversion_sequencer.sv
// conversion sequencer top with apb register slave
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [15:0] elem_result_in,
	output logic offset_polarity_out,
	output logic bandgap_state_out,
	output logic integrate_out,
	output logic busy_out
);
	// -----------------------------
	// registers and bus decode
	// -----------------------------
	logic [7:0] cfg0;
	logic [7:0] cfg2;
	logic [15:0] result;
	logic done_flag;
	logic wr_en;
	logic rd_en;
	logic hit_result;
	logic hit_cfg0;
	logic hit_cfg2;
	logic hit_status;
	logic hit_any;
	logic trigger;
	logic [31:0] next_rdata;
	assign wr_en = psel_in && penable_in && pwrite_in;
	assign rd_en = psel_in && penable_in && !pwrite_in;
	assign hit_result = (paddr_in == ADDR_RESULT);
	assign hit_cfg0 = (paddr_in == ADDR_CFG0);
	assign hit_cfg2 = (paddr_in == ADDR_CFG2);
	assign hit_status = (paddr_in == ADDR_STATUS);
	assign hit_any = hit_result || hit_cfg0 || hit_cfg2 || hit_status;
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in && !hit_any;
	// either trigger bit written as one starts a conversion
	assign trigger = wr_en && hit_cfg0 && (pwdata_in[CFG0_START_BIT] || pwdata_in[CFG0_ALT_BIT]); // RL1
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (hit_result)
			next_rdata = {16'h0000, result};
		else if (hit_cfg0)
			next_rdata = {24'h000000, cfg0};
		else if (hit_cfg2)
			next_rdata = {24'h000000, cfg2};
		else if (hit_status)
			next_rdata = {30'h0, done_flag, busy_out};
	end
	assign prdata_out = rd_en ? next_rdata : 32'h0000_0000;
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			cfg0 <= CFG0_RESET;
			cfg2 <= CFG2_RESET;
		end
		else if (wr_en && hit_cfg0)
			// trigger bits self-clear
			cfg0 <= pwdata_in[7:0] & ~(8'h01 | 8'h80);
		else if (wr_en && hit_cfg2)
			cfg2 <= pwdata_in[7:0];
	end
	// -----------------------------
	// settings decode
	// -----------------------------
	logic [2:0] ratio_code;
	logic [1:0] count_code;
	logic [10:0] oversample_ratio;
	logic [3:0] elem_conv_count;
	logic [3:0] res_bits;
	logic continuous;
	bandgap_mode_e bg_mode;
	assign ratio_code = cfg0[CFG0_RATIO_LSB +: 3];
	assign count_code = cfg0[CFG0_COUNT_LSB +: 2];
	assign continuous = cfg0[CFG0_CONT_BIT];
	assign bg_mode = bandgap_mode_e'(cfg2[CFG2_BG_LSB +: 2]);
	assign oversample_ratio = 11'(11'h008 << ratio_code); // RL9
	assign elem_conv_count = 4'(4'h1 << count_code); // RL10
	// n = 2*(3+code)+count, clipped to register width
	assign res_bits = (5'(6 + 2 * ratio_code + count_code) > 5'd16) ? 4'hf
		: 4'(5 + 2 * ratio_code + count_code); // RL11
	// -----------------------------
	// timebase
	// -----------------------------
	strobe_if sif ();
	assign sif.freq_sel = cfg2[CFG2_FREQ_LSB +: 2]; // RL8
	oversample_timebase u_tb (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.sif(sif)
	);
	// -----------------------------
	// sequencer
	// -----------------------------
	seq_state_e state;
	seq_state_e next_state;
	logic [10:0] period_cnt;
	logic [3:0] elem_idx;
	logic [1:0] aux_cnt;
	logic [19:0] acc;
	logic polarity;
	logic bg_q;
	logic elem_last_period;
	logic elem_done;
	logic [15:0] mean;
	logic [15:0] masked;
	logic [15:0] keep_mask;
	logic [15:0] signed_term;
	assign sif.run = (state == ST_ELEM) || (state == ST_QUANT);
	assign elem_last_period = (period_cnt == oversample_ratio); // RL3
	assign elem_done = sif.fs_tick && elem_last_period;
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (trigger)
					next_state = ST_SETUP; // RL1
			ST_SETUP:
				if (aux_cnt == 2'(SETUP_CYCLES - 1))
					next_state = ST_ELEM; // RL6
			ST_ELEM:
				if (elem_done && elem_idx == elem_conv_count - 4'h1)
					next_state = ST_QUANT; // RL2
			ST_QUANT:
				if (sif.fs_tick)
					next_state = ST_END; // RL12
			ST_END:
				if (aux_cnt == 2'(END_CYCLES - 1))
					next_state = continuous ? ST_SETUP : ST_IDLE; // RL13
			default:
				next_state = ST_IDLE;
		endcase
	end
	// each elementary result enters with alternating sign
	assign signed_term = polarity ? (16'h0000 - elem_result_in) : elem_result_in; // RL5
	// mean: divide by the power-of-two count
	assign mean = 16'($signed(acc) >>> count_code); // RL4
	assign keep_mask = 16'hffff << (4'hf - res_bits);
	// dropped bits read as a single one just below the lsb kept
	assign masked = (res_bits == 4'hf) ? mean
		: ((mean & keep_mask) | (16'h0001 << (4'he - res_bits))); // RL17
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state <= ST_IDLE;
			period_cnt <= 11'h000;
			elem_idx <= 4'h0;
			aux_cnt <= 2'h0;
			acc <= 20'h00000;
			polarity <= 1'b0;
			bg_q <= 1'b1;
			result <= 16'h0000;
			done_flag <= 1'b0;
		end
		else
		begin
			state <= next_state;
			aux_cnt <= (next_state != state) ? 2'h0 : aux_cnt + 2'h1; // RL6
			if (state == ST_SETUP)
			begin
				period_cnt <= 11'h000;
				elem_idx <= 4'h0;
				acc <= 20'h00000;
				polarity <= 1'b0;
				bg_q <= (bg_mode != BG_LOW);
			end
			else if (state == ST_ELEM && sif.fs_tick)
			begin
				period_cnt <= elem_last_period ? 11'h000 : period_cnt + 11'h001; // RL3
				if (elem_last_period)
				begin
					acc <= acc + {{4{signed_term[15]}}, signed_term}; // RL4
					elem_idx <= elem_idx + 4'h1;
					polarity <= !polarity; // RL5
					if (bg_mode == BG_TOGGLE || (bg_mode == BG_HALF && elem_idx[0]))
						bg_q <= !bg_q; // RL7
				end
			end
			if (state == ST_QUANT && sif.fs_tick)
			begin
				// store, only at the end of the sequence; the 7fff clamp can never fire, so nothing saturates
				if ($signed(mean) > 16'sh7fff)
					result <= 16'h7fff; // RL16
				else
					result <= masked; // RL18
				done_flag <= 1'b1;
			end
			else if (trigger)
				done_flag <= 1'b0;
			if (bg_mode == BG_HIGH)
				bg_q <= 1'b1; // RL7
			else if (bg_mode == BG_LOW)
				bg_q <= 1'b0;
		end
	end
	assign offset_polarity_out = polarity;
	assign bandgap_state_out = bg_q;
	assign integrate_out = (state == ST_ELEM);
	assign busy_out = (state != ST_IDLE);
	// -----------------------------
	// checks
	// -----------------------------
	sequence s_last_elem;
		state == ST_ELEM ##1 state == ST_QUANT;
	endsequence
	property p_start;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(state == ST_IDLE && trigger) |=> state == ST_SETUP;
	endproperty
	a_start: assert property (p_start) else $error("trigger ignored"); // RL1
	property p_setup_len;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		$rose(state == ST_SETUP) |-> state == ST_SETUP ##1 state == ST_SETUP ##1 state == ST_ELEM;
	endproperty
	a_setup_len: assert property (p_setup_len) else $error("setup length wrong"); // RL6
	property p_quant_after;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		s_last_elem |-> elem_idx == elem_conv_count;
	endproperty
	a_quant_after: assert property (p_quant_after) else $error("wrong elem count"); // RL2
	property p_period;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(state == ST_ELEM && sif.fs_tick && !elem_last_period) |=> period_cnt == $past(period_cnt) + 11'h001;
	endproperty
	a_period: assert property (p_period) else $error("period count stuck"); // RL3
	property p_polarity;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(state == ST_ELEM && elem_done) |=> polarity != $past(polarity);
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity not flipped"); // RL5
	property p_bg_hold;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(bg_mode == BG_LOW && $past(bg_mode) == BG_LOW) |-> !bg_q;
	endproperty
	a_bg_hold: assert property (p_bg_hold) else $error("bandgap not held low"); // RL7
	property p_result_only_end;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		!$stable(result) |-> $past(state) == ST_QUANT;
	endproperty
	a_result_only_end: assert property (p_result_only_end) else $error("early result"); // RL18
	property p_cont;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(state == ST_END && continuous && aux_cnt == 2'h1) |=> state == ST_SETUP;
	endproperty
	a_cont: assert property (p_cont) else $error("continuous stop"); // RL13
	property p_quant_one;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(state == ST_QUANT && sif.fs_tick) |=> state == ST_END;
	endproperty
	a_quant_one: assert property (p_quant_one) else $error("quant length wrong"); // RL12
	sequence s_end_hold;
		state == ST_END ##1 state == ST_END;
	endsequence
	property p_end_len;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		$rose(state == ST_END) |-> s_end_hold ##1 (state == ST_SETUP || state == ST_IDLE);
	endproperty
	a_end_len: assert property (p_end_len) else $error("end length wrong"); // RL6
	// trigger bits must never stick, or a later cfg0 write would restart
	property p_trig_clear;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		!cfg0[CFG0_START_BIT] && !cfg0[CFG0_ALT_BIT];
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("trigger bit stuck"); // RL1
	property p_bg_high;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(bg_mode == BG_HIGH && $past(bg_mode) == BG_HIGH) |-> bg_q;
	endproperty
	a_bg_high: assert property (p_bg_high) else $error("bandgap not held high"); // RL7
	property p_pol_first;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		$rose(integrate_out) |-> !polarity;
	endproperty
	a_pol_first: assert property (p_pol_first) else $error("first polarity wrong"); // RL5
	property p_acc_hold;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(state == ST_ELEM && !elem_done) |=> acc == $past(acc);
	endproperty
	a_acc_hold: assert property (p_acc_hold) else $error("acc moved mid period"); // RL4
	property p_done_set;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(state == ST_QUANT && sif.fs_tick) |=> done_flag;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done not set"); // RL18
	property p_res_store;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(state == ST_QUANT && sif.fs_tick) |=> result == $past(masked);
	endproperty
	a_res_store: assert property (p_res_store) else $error("stored result wrong"); // RL17
	property p_integ_run;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		integrate_out |-> sif.run;
	endproperty
	a_integ_run: assert property (p_integ_run) else $error("integrate without strobe"); // RL3
endmodule
`default_nettype wire

// File: elem_source_model.sv
// analog front-end stand-in that feeds one result per elementary conversion
`timescale 1ns/1ps
`default_nettype none
module elem_source_model
(
	input wire logic clk_in,
	input wire logic integrate_in,
	input wire logic polarity_in,
	input wire logic [15:0] base_in,
	input wire logic [15:0] step_in,
	output logic [15:0] result_out
);
	logic pol_q;
	logic [3:0] idx;
	// advance a cycle after the flip, well clear of the sampling edge
	always_ff @(posedge clk_in)
	begin
		pol_q <= polarity_in;
		if (!integrate_in)
			idx <= 4'h0;
		else if (pol_q != polarity_in)
			idx <= idx + 4'h1;
	end
	assign result_out = base_in + 16'(idx) * step_in;
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import adc_seq_pkg::*;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, perr, pol, bg, integ, busy;
	logic [15:0] elem, last = 16'h0;
	logic [15:0] base = 16'h0;
	logic [15:0] step = 16'h0;
	int n_fail = 0;
	int check_count = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	adc_conversion_sequencer u_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .elem_result_in(elem), .offset_polarity_out(pol),
		.bandgap_state_out(bg), .integrate_out(integ), .busy_out(busy));
	elem_source_model u_src (.clk_in(clk_sys_in), .integrate_in(integ),
		.polarity_in(pol), .base_in(base), .step_in(step), .result_out(elem));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		do @(posedge clk_sys_in); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// mean of alternately negated samples, then the forced low bits
	function automatic logic [15:0] model(input int r, input int c);
		int sum;
		int res;
		logic [15:0] m;
		sum = 0;
		for (int k = 0; k < (1 << c); k++)
			sum += (k % 2 ? -1 : 1) * (int'(base) + k * int'(step));
		m = 16'(sum >>> c);
		res = 2 * (3 + r) + c;
		if (res < 16)
			m = (m & ~(16'hffff >> res)) | (16'h8000 >> res);
		return m;
	endfunction
	task automatic run(input int f, input int g, input int r, input int c, input int t);
		int ni, nb, bt, p, e, bx;
		p = (64 >> f) * 25;
		e = (1 << c) * ((8 << r) + 1) * p;
		ni = 0;
		nb = 0;
		bt = 0;
		apb(1'b1, ADDR_CFG2, 32'((f << CFG2_FREQ_LSB) | g));
		apb(1'b1, ADDR_CFG0, 32'((1 << t) | (r << CFG0_RATIO_LSB) | (c << CFG0_COUNT_LSB)));
		@(negedge clk_sys_in);
		check("busy", 32'(busy), 32'h1);
		apb(1'b0, ADDR_RESULT, 32'h0);
		check("held result", rd, 32'(last));
		while (busy === 1'b1)
		begin
			@(negedge clk_sys_in);
			bt++;
			ni += int'(integ === 1'b1);
			nb += int'(integ === 1'b1 && bg === (g == 0));
		end
		check("integrate span", 32'(ni >= e - p && ni <= e + p), 32'h1);
		e = e + p + SETUP_CYCLES + END_CYCLES;
		check("busy span", 32'(bt >= e - p && bt <= e + p), 32'h1);
		if (g < 2)
			check("bandgap", 32'(nb), 32'(ni));
		// toggle flips once per element, half rate once per pair, from high
		bx = (g == 0) ? 1 : (g == 1) ? 0 : 1 - ((g == 2) ? ((1 << c) & 1) : (((1 << c) >> 1) & 1));
		check("bandgap end", 32'(bg), 32'(bx));
		apb(1'b0, ADDR_RESULT, 32'h0);
		last = model(r, c);
		check("result", rd, 32'(last));
		apb(1'b0, ADDR_STATUS, 32'h0);
		check("status", rd, 32'h2);
		$display("test done f=%0d g=%0d r=%0d c=%0d", f, g, r, c);
	endtask
	initial
	begin
		#950000;
		n_fail++;
		close_out();
	end
	initial
	begin
		void'($urandom(32'h22de91b8));
		repeat (6) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		base <= 16'($urandom_range(16'h3fff));
		step <= 16'($urandom_range(16'h00ff));
		apb(1'b0, ADDR_CFG0, 32'h0);
		check("cfg0 reset", rd, 32'(CFG0_RESET));
		apb(1'b0, ADDR_CFG2, 32'h0);
		check("cfg2 reset", rd, 32'(CFG2_RESET));
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped", {perr, rd[30:0]}, 32'h80000000);
		for (int f = 0; f < 4; f++)
			run(f, f, 0, 0, CFG0_START_BIT);
		for (int i = 0; i < 2; i++)
		begin
			base <= 16'($urandom_range(16'h3fff));
			step <= 16'($urandom_range(16'h00ff));
			run(3, 2 + i, $urandom_range(1), 1 + $urandom_range(1), CFG0_ALT_BIT);
		end
		apb(1'b1, ADDR_CFG0, 32'((1 << CFG0_START_BIT) | (1 << CFG0_CONT_BIT)));
		repeat (2600) @(negedge clk_sys_in);
		check("continuous busy", 32'(busy), 32'h1);
		apb(1'b1, ADDR_CFG0, 32'h0);
		while (busy === 1'b1)
			@(negedge clk_sys_in);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check("continuous done", rd, 32'h2);
		apb(1'b0, ADDR_RESULT, 32'h0);
		check("continuous result", rd, 32'(model(0, 0)));
		$display("test done continuous");
		close_out();
	end
endmodule
`default_nettype wire
